// File: logic/rwe_config_reg.sv
`timescale 1ns/10ps
module rwe_config_reg (
  input wire logic mclk,
  input wire logic srst,
  input wire logic porRst,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic regSelNv,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  output logic regRdValid,
  output logic [2:0] driveStrengthCode,
  output logic wrapBurstEnable,
  output logic [1:0] wrapLengthSelect,
  output logic eccModeSelect,
  input wire logic burstStart,
  input wire logic [rwe_pkg::ADDR_W-1:0] burstStartAddr,
  input wire logic burstNext,
  input wire logic burstStop,
  output logic [rwe_pkg::ADDR_W-1:0] burstAddr,
  output logic burstActive
);
  import rwe_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] nvCfg;
    logic [7:0] volCfg;
    logic [7:0] rdData;
    logic rdValid;
    rwe_burst_type burst;
    logic [ADDR_W-1:0] addr;
  } rwe_state_type;

  rwe_state_type state_q;
  rwe_state_type state_d;

  rwe_wrap_if wif ();

  rwe_wrap_addr u_wrap (
    .wif(wif)
  );

  // ----------------------------------------
  // wrap address feed
  // ----------------------------------------
  assign wif.wrapEn = state_q.volCfg[WRAP_EN_BIT]; // RULE2
  assign wif.wrapLen = state_q.volCfg[WRAP_LEN_MSB:WRAP_LEN_LSB]; // RULE3
  assign wif.curAddr = state_q.addr;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    state_d.rdValid = 1'b0;
    if (porRst) begin
      state_d.nvCfg = FACTORY_DEFAULT; // RULE1 RULE4
      state_d.volCfg = FACTORY_DEFAULT;
      state_d.rdData = 8'h00;
      state_d.burst = BURST_IDLE;
      state_d.addr = ADDR_RESET;
    end else if (srst) begin
      // non-volatile copy survives a hardware reset
      state_d.volCfg = state_q.nvCfg; // RULE10
      state_d.rdData = 8'h00;
      state_d.burst = BURST_IDLE;
      state_d.addr = ADDR_RESET;
    end else begin
      if (regWrEn) begin
        if (regSelNv) begin
          state_d.nvCfg = regWrData; // RULE7
        end else begin
          // ecc change here leaves old check bits; host must erase and reprogram
          state_d.volCfg = (regWrData & VOL_WRITE_MASK) | (state_q.volCfg & ~VOL_WRITE_MASK); // RULE7
        end
      end
      if (regRdEn) begin
        state_d.rdData = regSelNv ? state_q.nvCfg : state_q.volCfg; // RULE7
        state_d.rdValid = 1'b1;
      end
      unique case (state_q.burst)
        BURST_IDLE: begin
          if (burstStart) begin
            state_d.addr = burstStartAddr;
            state_d.burst = BURST_RUN;
          end
        end
        BURST_RUN: begin
          if (burstStop) begin
            state_d.burst = BURST_IDLE;
          end else if (burstNext) begin
            // live wrap bit: mode can be entered or left mid-burst
            state_d.addr = wif.nextAddr; // RULE2 RULE9
          end
        end
        default: begin
          state_d.burst = BURST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    state_q <= state_d;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign regRdData = state_q.rdData;
  assign regRdValid = state_q.rdValid;
  assign driveStrengthCode = state_q.volCfg[DRV_MSB:DRV_LSB]; // RULE1
  assign wrapBurstEnable = state_q.volCfg[WRAP_EN_BIT]; // RULE2
  assign wrapLengthSelect = state_q.volCfg[WRAP_LEN_MSB:WRAP_LEN_LSB]; // RULE3
  assign eccModeSelect = state_q.volCfg[ECC_MODE_BIT]; // RULE4 RULE5
  assign burstAddr = state_q.addr;
  // one-hot run bit, taken straight from the state flop
  assign burstActive = state_q.burst[1];

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst || porRst);

  sequence sVolWrite;
    regWrEn && !regSelNv;
  endsequence

  sequence sNvWrite;
    regWrEn && regSelNv;
  endsequence

  sequence sStep;
    burstActive && burstNext && !burstStop && !regWrEn;
  endsequence

  a_vol_drive_write: assert property (sVolWrite |=> driveStrengthCode == $past(regWrData[7:5])) // RULE1
    else $error("drive strength not taken from volatile write");

  a_vol_ecc_write: assert property (sVolWrite |=> eccModeSelect == $past(regWrData[3])) // RULE4
    else $error("ecc mode not taken from volatile write");

  a_vol_wrap_write: assert property (sVolWrite |=> wrapBurstEnable == $past(regWrData[4])) // RULE2
    else $error("wrap enable lost after volatile write");

  a_nv_write_only: assert property (sNvWrite |=> $stable(state_q.volCfg)
    && state_q.nvCfg == $past(regWrData)) // RULE7
    else $error("non-volatile write wrong or disturbed volatile copy");

  a_read_returns: assert property (regRdEn |=> regRdValid
    && regRdData == ($past(regSelNv) ? $past(state_q.nvCfg) : $past(state_q.volCfg))) // RULE7
    else $error("register read returned wrong copy");

  a_reset_load_vol: assert property (@(posedge mclk) disable iff (porRst)
    srst |=> state_q.volCfg == $past(state_q.nvCfg) && !burstActive) // RULE10
    else $error("reset did not load volatile from non-volatile copy");

  a_por_default: assert property (@(posedge mclk) disable iff (1'b0)
    porRst |=> driveStrengthCode == 3'b101 && eccModeSelect && !wrapBurstEnable) // RULE1
    else $error("factory defaults not applied");

  a_wrap_in_group: assert property ((sStep and wrapBurstEnable) |=> burstAddr[31:6]
    == $past(burstAddr[31:6]) && ((burstAddr[5:0] ^ $past(burstAddr[5:0]))
    & ~rwe_wrap_mask($past(wrapLengthSelect))) == 6'h00) // RULE9 RULE3
    else $error("wrapped burst left its group");

  a_wrap_to_low: assert property ((sStep and (wrapBurstEnable
    && (burstAddr[5:0] & rwe_wrap_mask(wrapLengthSelect)) == rwe_wrap_mask(wrapLengthSelect)))
    |=> (burstAddr[5:0] & rwe_wrap_mask($past(wrapLengthSelect))) == 6'h00) // RULE8
    else $error("wrapped burst did not return to group base");

  a_linear_step: assert property ((sStep and !wrapBurstEnable)
    |=> burstAddr == $past(burstAddr) + 32'h0000_0001) // RULE2
    else $error("unwrapped burst did not step by one");

  // ----------------------------------------
  // register copy assertions
  // ----------------------------------------

  a_vol_len_write: assert property ( // RULE3
    sVolWrite |=> wrapLengthSelect == $past(regWrData[1:0]))
    else $error("wrap length not taken from volatile write");

  a_sleep_bit_kept: assert property ( // RULE7
    sVolWrite |=> state_q.volCfg[DPD_BIT] == $past(state_q.volCfg[DPD_BIT]))
    else $error("read-only volatile bit changed by a write");

  a_por_nv_default: assert property (@(posedge mclk) disable iff (1'b0) // RULE1 RULE4 RULE7
    porRst |=> state_q.nvCfg == FACTORY_DEFAULT)
    else $error("non-volatile copy missed its factory default");

  a_vol_steady: assert property ( // RULE7
    !(regWrEn && !regSelNv) |=> $stable(state_q.volCfg))
    else $error("volatile copy changed without a write");

  a_nv_steady: assert property ( // RULE7
    !(regWrEn && regSelNv) |=> $stable(state_q.nvCfg))
    else $error("non-volatile copy changed without a write");

  a_read_pulse: assert property ( // RULE7
    !regRdEn |=> !regRdValid)
    else $error("read valid without a read strobe");

  // ----------------------------------------
  // burst assertions
  // ----------------------------------------

  sequence sBurstStart;
    !burstActive && burstStart;
  endsequence

  sequence sBurstStop;
    burstActive && burstStop;
  endsequence

  a_start_load: assert property ( // RULE9
    sBurstStart |=> burstActive && burstAddr == $past(burstStartAddr))
    else $error("burst start address not loaded");

  a_stop_ends: assert property ( // RULE9
    sBurstStop |=> !burstActive)
    else $error("burst did not end on stop");

  a_idle_hold: assert property ( // RULE9
    !burstActive && !burstStart |=> !burstActive && $stable(burstAddr))
    else $error("idle burst logic moved");

  a_run_hold: assert property ( // RULE9
    burstActive && !burstNext && !burstStop |=> burstActive && $stable(burstAddr))
    else $error("running burst moved without a step");

endmodule : rwe_config_reg

// File: common/rwe_pkg.sv
// What this block does
// RULE1: the volatile drive strength code in bits 7 to 5 drives the output drivers, default 101.
// RULE2: bit 4 enables wrapped main array bursts and may be changed at any time.
// RULE3: while wrapping is on, the wrap length comes from bits 1 to 0 of the same register.
// RULE4: bit 3 selects ECC mode, 0 single-bit correction, 1 adds double-bit detection, default 1.
// RULE5: the selected ECC mode is handed to the address trap and error counter logic.
// RULE6: after an ECC mode change the host must erase and reprogram the affected data.
// RULE7: drive strength, wrap enable and ECC mode exist in a non-volatile and a volatile copy.
// RULE8: wrap length code 00, 01, 10, 11 selects an 8, 16, 32 or 64 byte group.
// RULE9: a wrapped burst stays in its aligned group and wraps from its top to its bottom.
// RULE10: reset loads the volatile copy from the non-volatile copy.
package rwe_pkg;

  // ----------------------------------------
  // field layout
  // ----------------------------------------
  localparam int DRV_MSB = 7;
  localparam int DRV_LSB = 5;
  localparam int WRAP_EN_BIT = 4;
  localparam int ECC_MODE_BIT = 3;
  localparam int DPD_BIT = 2;
  localparam int WRAP_LEN_MSB = 1;
  localparam int WRAP_LEN_LSB = 0;
  localparam int ADDR_W = 32;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] FACTORY_DEFAULT = 8'hA8;
  // power-on-DPD bit is read-only in the volatile copy
  localparam logic [7:0] VOL_WRITE_MASK = 8'hFB;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 32'h0000_0000;

  // ----------------------------------------
  // wrap group masks
  // ----------------------------------------
  localparam logic [5:0] WRAP8_MASK = 6'h07;
  localparam logic [5:0] WRAP16_MASK = 6'h0F;
  localparam logic [5:0] WRAP32_MASK = 6'h1F;
  localparam logic [5:0] WRAP64_MASK = 6'h3F;

  typedef enum logic [1:0] {
    BURST_IDLE = 2'b01,
    BURST_RUN = 2'b10
  } rwe_burst_type;

  function automatic logic [5:0] rwe_wrap_mask(input logic [1:0] sel);
    logic [5:0] m;
    unique case (sel)
      2'b00: m = WRAP8_MASK;
      2'b01: m = WRAP16_MASK;
      2'b10: m = WRAP32_MASK;
      2'b11: m = WRAP64_MASK;
    endcase
    return m;
  endfunction : rwe_wrap_mask

endpackage : rwe_pkg

// File: common/rwe_wrap_if.sv
`timescale 1ns/10ps
interface rwe_wrap_if;
  logic wrapEn;
  logic [1:0] wrapLen;
  logic [31:0] curAddr;
  logic [31:0] nextAddr;
  modport cfg (output wrapEn, output wrapLen, output curAddr, input nextAddr);
  modport calc (input wrapEn, input wrapLen, input curAddr, output nextAddr);
endinterface : rwe_wrap_if

// File: logic/rwe_wrap_addr.sv
`timescale 1ns/10ps
module rwe_wrap_addr (
  rwe_wrap_if.calc wif
);
  import rwe_pkg::*;

  logic [5:0] mask;
  logic [5:0] lowInc;

  always_comb begin
    mask = rwe_wrap_mask(wif.wrapLen); // RULE8
    lowInc = wif.curAddr[5:0] + 6'h01;
    if (wif.wrapEn) begin // RULE2 RULE3
      // upper bits stay put, so the burst never leaves its aligned group
      wif.nextAddr = {wif.curAddr[31:6], (wif.curAddr[5:0] & ~mask) | (lowInc & mask)}; // RULE9
    end else begin
      wif.nextAddr = wif.curAddr + 32'h0000_0001;
    end
  end

endmodule : rwe_wrap_addr

// File: tb/rwe_host_model.sv
`timescale 1ns/10ps
module rwe_host_model (
  input wire logic mclk,
  output logic regWrEn,
  output logic regRdEn,
  output logic regSelNv,
  output logic [7:0] regWrData
);
  initial begin
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regSelNv = 1'b0;
    regWrData = 8'h00;
  end
  // ----------------------------------------
  // one register transaction
  // ----------------------------------------
  // an ecc mode change is never followed by an array rewrite here: no array is modelled
  task automatic xfer(input logic wr, input logic nv, input logic [7:0] d);
    @(negedge mclk);
    regSelNv = nv;
    regWrData = d;
    regWrEn = wr;
    regRdEn = ~wr;
    @(negedge mclk);
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    // released data lines must not keep the last byte
    regWrData = ~d;
  endtask : xfer
endmodule : rwe_host_model

// File: tb/testbench.sv
`timescale 1ns/10ps
module testbench;
  import rwe_pkg::*;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic porRst = 1'b1;
  logic regWrEn, regRdEn, regSelNv, regRdValid, wrapBurstEnable, eccModeSelect, burstActive;
  logic [7:0] regWrData, regRdData, v, nv, vol;
  logic [2:0] driveStrengthCode;
  logic [1:0] wrapLengthSelect;
  logic burstStart = 1'b0;
  logic burstNext = 1'b0;
  logic burstStop = 1'b0;
  logic [31:0] burstStartAddr = 32'h0, burstAddr, a;
  int badCount = 0;
  int checked = 0;
  always #25 mclk = ~mclk;
  rwe_host_model u_host (.mclk(mclk), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regSelNv(regSelNv), .regWrData(regWrData));
  rwe_config_reg u_dut (.mclk(mclk), .srst(srst), .porRst(porRst), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regSelNv(regSelNv), .regWrData(regWrData), .regRdData(regRdData),
    .regRdValid(regRdValid), .driveStrengthCode(driveStrengthCode),
    .wrapBurstEnable(wrapBurstEnable), .wrapLengthSelect(wrapLengthSelect),
    .eccModeSelect(eccModeSelect), .burstStart(burstStart), .burstStartAddr(burstStartAddr),
    .burstNext(burstNext), .burstStop(burstStop), .burstAddr(burstAddr),
    .burstActive(burstActive));
  // ----------------------------------------
  // checking helpers
  // ----------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      badCount++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", checked, badCount);
    if (badCount == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude
  function automatic logic [31:0] nxt(input logic [31:0] x, input logic en, input logic [1:0] l);
    logic [5:0] m;
    m = 6'((7'd8 << l) - 7'd1);
    return en ? {x[31:6], (x[5:0] & ~m) | ((x[5:0] + 6'd1) & m)} : x + 32'd1;
  endfunction : nxt
  task automatic cfg_chk(input logic [7:0] e);
    chk("drive", 32'(e[7:5]), 32'(driveStrengthCode));
    chk("wrapEn", 32'(e[4]), 32'(wrapBurstEnable));
    chk("ecc", 32'(e[3]), 32'(eccModeSelect));
    chk("wrapLen", 32'(e[1:0]), 32'(wrapLengthSelect));
  endtask : cfg_chk
  task automatic rd_chk(input logic sel, input logic [7:0] e);
    u_host.xfer(1'b0, sel, 8'h00);
    chk("rdValid", 32'h1, 32'(regRdValid));
    chk("rdData", 32'(e), 32'(regRdData));
  endtask : rd_chk
  // ----------------------------------------
  // hang guard, about 20000 cycles
  // ----------------------------------------
  initial begin
    #1000000;
    badCount++;
    conclude();
  end
  initial begin
    void'($urandom(32'h3DF0));
    repeat (8) @(negedge mclk);
    porRst = 1'b0;
    srst = 1'b0;
    rd_chk(1'b1, 8'hA8);
    rd_chk(1'b0, 8'hA8);
    cfg_chk(8'hA8);
    vol = 8'hA8;
    for (int i = 0; i < 40; i++) begin
      v = (i == 0) ? 8'hFF : 8'($urandom);
      nv = (i == 1) ? 8'h00 : 8'($urandom);
      u_host.xfer(1'b1, 1'b1, nv);
      u_host.xfer(1'b1, 1'b0, v);
      // volatile bit 2 only follows the stored copy
      vol = (v & VOL_WRITE_MASK) | (vol & ~VOL_WRITE_MASK);
      cfg_chk(vol);
      rd_chk(1'b0, vol);
      rd_chk(1'b1, nv);
      if (i % 4 == 3) begin
        srst = 1'b1;
        @(negedge mclk);
        srst = 1'b0;
        vol = nv;
        cfg_chk(vol);
        rd_chk(1'b0, vol);
      end
    end
    for (int i = 0; i < 8; i++) begin
      u_host.xfer(1'b1, 1'b0, {3'b101, i[2], 2'b10, i[1:0]});
      a = $urandom;
      if (i[0]) begin
        a[5:0] = 6'h3F;
      end
      @(negedge mclk);
      burstStart = 1'b1;
      burstStartAddr = a;
      @(negedge mclk);
      burstStart = 1'b0;
      burstStartAddr = ~a;
      chk("active", 32'h1, 32'(burstActive));
      chk("addr", a, burstAddr);
      // one idle cycle: a running burst must hold its address
      @(negedge mclk);
      chk("hold", a, burstAddr);
      burstNext = 1'b1;
      for (int k = 0; k < 70; k++) begin
        // a second start inside a run must be ignored
        burstStart = (k == 3);
        @(negedge mclk);
        a = nxt(a, i[2], i[1:0]);
        chk("addr", a, burstAddr);
      end
      burstStart = 1'b0;
      burstStop = 1'b1;
      @(negedge mclk);
      burstStop = 1'b0;
      burstNext = 1'b0;
      chk("active", 32'h0, 32'(burstActive));
    end
    conclude();
  end
endmodule : testbench
